// >>> cdr_dram_model.sv
// Pin-level model of the cached DRAM module that the host drives.
// Assumes pins come from registered host outputs; rows 0-7, columns 0-7 kept.
`timescale 1ns/1ns
`default_nettype none
module cdr_dram_model (
  input wire logic row_strobe_n,
  input wire logic select_n,
  input wire logic write_read_select,
  input wire logic refresh_req_n,
  input wire logic [3:0] byte_col_latch_n,
  input wire logic parity_col_latch_n,
  input wire logic write_strobe_n,
  input wire logic output_en_n,
  input wire logic [10:0] addr,
  input wire logic [35:0] dq_o,
  input wire logic dq_oe,
  output logic [35:0] dq_i
);
  // ****
  // Storage and state
  // ****
  logic [35:0] mem [0:63]; // Small array keeps the model cheap
  logic [35:0] cache [0:7];
  logic [35:0] held = 36'h000000000; // Last driven word, inverted when idle
  logic [35:0] w;
  logic [10:0] last_read_row_latch = 11'h000;
  logic [10:0] row = 11'h000;
  logic lrr_known = 1'b0;
  logic wr_mode = 1'b0;
  logic ref_cyc = 1'b0;
  logic hit = 1'b0;
  logic inhibit = 1'b0;
  logic self_on = 1'b0;
  logic posted = 1'b0;
  logic [3:0] mask = 4'h0;
  time self_exit = 0;
  int refreshes = 0;
  int reads = 0;
  int row_only = 0;
  int selfs = 0;
  int bad = 0;
  // Static column read, also during precharge; off in standby or write miss
  wire drive = !select_n && !output_en_n && !inhibit && !self_on;
  // Released bus shows the inverse of the last word, never a kept value
  assign dq_i = dq_oe ? dq_o : (drive ? cache[addr[2:0]] : ~held);
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = {30'h00000000, 6'(i)};
  end
  always @(negedge drive)
    held = cache[addr[2:0]];
  // ****
  // Row strobe fall decodes the cycle
  // ****
  always @(negedge row_strobe_n)
  begin
    #1;
    posted = 1'b0;
    if (self_exit != 0 && $time - self_exit < 120)
      bad++;
    if (!refresh_req_n)
      ref_cyc = 1'b1;
    else if (select_n && write_read_select && write_strobe_n && byte_col_latch_n == 4'h0)
    begin
      self_on = 1'b1;
      selfs++;
    end
    else if (select_n)
      bad++;
    else if (write_read_select)
    begin
      if (byte_col_latch_n != 4'hF || !write_strobe_n)
        bad++;
      wr_mode = 1'b1;
      row = addr;
      hit = lrr_known && addr == last_read_row_latch;
      inhibit = !hit;
      mask = {dq_i[35], dq_i[26], dq_i[17], dq_i[8]};
    end
    else
    begin
      reads++;
      if (!lrr_known || addr != last_read_row_latch)
      begin
        for (int i = 0; i < 8; i++)
          cache[i] = mem[{addr[2:0], 3'(i)}];
        last_read_row_latch = addr;
        lrr_known = 1'b1;
      end
    end
  end
  // Post a write only where latch and write strobe are both low
  always @(negedge write_strobe_n)
  begin
    #1;
    if (wr_mode)
    begin
      w = mem[{row[2:0], addr[2:0]}];
      for (int i = 0; i < 4; i++)
      begin
        if (!byte_col_latch_n[i])
          w[9*i+:8] = dq_i[9*i+:8];
        if (!parity_col_latch_n && mask[i])
          w[9*i+8] = dq_i[9*i+8];
      end
      mem[{row[2:0], addr[2:0]}] = w;
      if (hit)
        cache[addr[2:0]] = w;
      posted = 1'b1;
    end
  end
  // Row strobe rise ends the cycle
  always @(posedge row_strobe_n)
  begin
    if (self_on)
      self_exit = $time;
    self_on = 1'b0;
    if (ref_cyc)
      refreshes++;
    ref_cyc = 1'b0;
    if (wr_mode && !posted)
      row_only++;
    wr_mode = 1'b0;
    fork
      #120 inhibit = 1'b0;
    join_none
  end
endmodule // cdr_dram_model
`default_nettype wire

// >>> cdr_host_ctrl.sv
// Host side controller that drives a cached DRAM module through its pins.
// Assumes pins meet the module at 25 MHz with registered outputs and
// that read data returns through two synchroniser stages.
`timescale 1ns/1ns
`default_nettype none
`include "cdr_map.svh"
module cdr_host_ctrl #(
  parameter int unsigned REFRESH_GAP_CYC = `CDR_REFRESH_GAP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire cdr_pkg::cdr_cmd_t req_cmd,
  input wire logic [`CDR_ADDR_W-1:0] req_row,
  input wire logic [`CDR_COL_W-1:0] req_col,
  input wire logic [`CDR_DATA_W-1:0] req_wdata,
  input wire logic [`CDR_LANES-1:0] req_byte_en,
  input wire logic [`CDR_LANES-1:0] req_par_mask,
  input wire logic self_refresh_hold,
  output logic rsp_valid,
  output logic [`CDR_DATA_W-1:0] rsp_rdata,
  output logic init_done,
  output logic cache_hit,
  output logic row_strobe_n,
  output logic select_n,
  output logic write_read_select,
  output logic refresh_req_n,
  output logic [`CDR_LANES-1:0] byte_col_latch_n,
  output logic parity_col_latch_n,
  output logic write_strobe_n,
  output logic output_en_n,
  output logic [`CDR_ADDR_W-1:0] addr,
  output logic [`CDR_DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [`CDR_DATA_W-1:0] dq_i
);
  import cdr_pkg::*;
  // ************************************************
  // Phase lengths, stored as count minus one
  // ************************************************
  localparam logic [7:0] ROW_HOLD = 8'(`CDR_CEIL_CYC(`CDR_ROW_HOLD_NS) - 1);
  localparam logic [7:0] ROW_ACTIVE = 8'(`CDR_CEIL_CYC(`CDR_ROW_ACTIVE_NS) - 1);
  localparam logic [7:0] ACCESS_LEN = 8'(`CDR_CEIL_CYC(`CDR_ACCESS_NS) + `CDR_SYNC_STAGES - 1);
  localparam logic [7:0] WRITE_LEN = 8'(`CDR_CEIL_CYC(`CDR_WRITE_NS) - 1);
  localparam logic [7:0] PRE_LEN = 8'(`CDR_CEIL_CYC(`CDR_PRECHARGE_NS) - 1);
  localparam logic [7:0] WRR_LEN = 8'(`CDR_CEIL_CYC(`CDR_WRR_NS) - 1);
  localparam logic [7:0] SR_EXIT_LEN = 8'(`CDR_CEIL_CYC(`CDR_SR_EXIT_NS) - 1);
  localparam logic [7:0] INIT_LEN = 8'(`CDR_INIT_WAIT_CYC - 1);
  localparam int unsigned GW = $clog2(REFRESH_GAP_CYC + 1) + 1;
  cdr_state_t state; // Sequencer phase
  cdr_cmd_t op; // Operation in flight
  cdr_cmd_t next_op; // Operation picked in idle
  logic [`CDR_ADDR_W-1:0] next_row; // Row picked in idle
  logic start; // Idle picks an operation
  logic [7:0] cnt; // Phase countdown
  logic [`CDR_ADDR_W-1:0] row_q; // Row of operation in flight
  logic [`CDR_COL_W-1:0] col_q; // Column of operation in flight
  logic [`CDR_DATA_W-1:0] wdata_q; // Write data held for the column phase
  logic [`CDR_LANES-1:0] ben_q; // Byte enables held
  logic [`CDR_LANES-1:0] pmask_q; // Parity mask held
  logic [`CDR_DATA_W-1:0] mask_word; // Parity mask placed on the bus
  logic [3:0] init_step; // Start-up cycles done
  logic [`CDR_ADDR_W-1:0] lrr_row; // Copy of the module's last read row
  logic lrr_valid; // Copy is known
  logic wr_miss; // Write cycle to a row outside the cache
  logic refresh_due; // Refresh interval elapsed
  logic phase_done; // Countdown at zero
  logic [`CDR_DATA_W-1:0] dq_s1; // Synchroniser first stage
  logic [`CDR_DATA_W-1:0] dq_s2; // Synchroniser second stage
  assign phase_done = (cnt == 8'h00);
  assign wr_miss = (op == CMD_WRITE || op == CMD_ROW_REFRESH) && !(lrr_valid && row_q == lrr_row);
  assign req_ready = (state == ST_IDLE) && init_done && !refresh_due;
  assign cache_hit = lrr_valid && (req_row == lrr_row);
  // Parity pins sit at the top of each nine-bit lane
  for (genvar i = 0; i < `CDR_LANES; i++)
  begin : g_mask
    for (genvar b = 0; b < `CDR_LANE_BITS; b++)
    begin : g_bit
      if (b == `CDR_PAR_POS)
      begin : g_par
        assign mask_word[i*`CDR_LANE_BITS+b] = pmask_q[i];
      end
      else
      begin : g_data
        assign mask_word[i*`CDR_LANE_BITS+b] = 1'b0;
      end
    end
  end
  // ************************************************
  // Refresh timer
  // ************************************************
  // Due a little early so an operation in flight cannot overrun the gap
  cdr_interval_timer #(
    .PERIOD(REFRESH_GAP_CYC - `CDR_REFRESH_SLACK_CYC)
  ) u_refresh_timer (
    .clk(clk),
    .nrst(nrst),
    .clear(start && next_op == CMD_REFRESH),
    .due(refresh_due)
  );
  // ************************************************
  // Operation choice
  // ************************************************
  // Start-up first, then refresh, then the user; reads never stand in for refresh
  always_comb
  begin
    start = 1'b0;
    next_op = CMD_READ;
    next_row = req_row;
    if (state == ST_IDLE)
    begin
      if (!init_done)
      begin
        start = 1'b1;
        next_op = (init_step < 4'(`CDR_INIT_REFRESHES)) ? CMD_REFRESH : CMD_READ;
        next_row = {{(`CDR_ADDR_W-1){1'b0}}, init_step[0]}; // Two distinct rows
      end
      else if (refresh_due)
      begin
        start = 1'b1;
        next_op = CMD_REFRESH;
      end
      else if (req_valid)
      begin
        start = 1'b1;
        next_op = req_cmd;
      end
    end
  end
  // ************************************************
  // Sequencer
  // ************************************************
  // Phase order: setup, row, column, access, release, precharge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_POWERUP;
      cnt <= INIT_LEN;
    end
    else
    begin
      unique case (state)
        ST_POWERUP:
        begin
          if (phase_done)
            state <= ST_IDLE;
          else
            cnt <= cnt - 8'h01;
        end
        ST_IDLE:
        begin
          if (start)
            state <= ST_SETUP;
        end
        ST_SETUP:
        begin
          state <= ST_ROW;
          if (op == CMD_READ || op == CMD_WRITE)
            cnt <= ROW_HOLD;
          else if (op == CMD_SELF_REFRESH)
            cnt <= 8'h00;
          else
            cnt <= ROW_ACTIVE;
        end
        ST_ROW:
        begin
          if (!phase_done)
            cnt <= cnt - 8'h01;
          else if (op == CMD_READ || op == CMD_WRITE)
            state <= ST_COL;
          else if (op == CMD_SELF_REFRESH)
            state <= ST_SELF;
          else
            state <= ST_RELEASE;
        end
        ST_COL:
        begin
          state <= ST_ACCESS;
          cnt <= (op == CMD_READ) ? ACCESS_LEN : WRITE_LEN;
        end
        ST_ACCESS:
        begin
          if (phase_done)
            state <= ST_RELEASE;
          else
            cnt <= cnt - 8'h01;
        end
        ST_SELF:
        begin
          if (!self_refresh_hold)
          begin
            state <= ST_PRE;
            cnt <= SR_EXIT_LEN;
          end
        end
        ST_RELEASE:
        begin
          state <= ST_PRE;
          cnt <= (wr_miss && WRR_LEN > PRE_LEN) ? WRR_LEN : PRE_LEN;
        end
        ST_PRE:
        begin
          if (phase_done)
            state <= ST_IDLE;
          else
            cnt <= cnt - 8'h01;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
  // Operation and its operands, held for the whole cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op <= CMD_READ;
      row_q <= '0;
      col_q <= '0;
      wdata_q <= '0;
      ben_q <= '0;
      pmask_q <= '0;
    end
    else if (start)
    begin
      op <= next_op;
      row_q <= next_row;
      col_q <= init_done ? req_col : '0;
      wdata_q <= req_wdata;
      ben_q <= init_done ? req_byte_en : '0;
      pmask_q <= init_done ? req_par_mask : '0;
    end
  end
  // ************************************************
  // Row, select and mode pins
  // ************************************************
  // Idle leaves the module deselected so it sits in standby
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      row_strobe_n <= 1'b1;
      select_n <= 1'b1;
      write_read_select <= 1'b0;
      refresh_req_n <= 1'b1;
      addr <= '0;
    end
    else if (start)
    begin
      // Refresh and self refresh run deselected; the rest are selected
      select_n <= (next_op == CMD_REFRESH || next_op == CMD_SELF_REFRESH);
      write_read_select <= (next_op != CMD_READ);
      refresh_req_n <= (next_op != CMD_REFRESH);
      addr <= next_row;
    end
    else if (state == ST_SETUP)
      row_strobe_n <= 1'b0;
    else if (state == ST_ROW && phase_done && (op == CMD_READ || op == CMD_WRITE))
      addr <= {{(`CDR_ADDR_W-`CDR_COL_W){1'b0}}, col_q};
    else if (state == ST_RELEASE || (state == ST_SELF && !self_refresh_hold))
      row_strobe_n <= 1'b1;
    else if (state == ST_PRE)
    begin
      select_n <= 1'b1;
      refresh_req_n <= 1'b1;
    end
  end
  // ************************************************
  // Column strobes, write strobe, output enable and data
  // ************************************************
  // Mask rides the bus at the row fall, data follows it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      byte_col_latch_n <= '1;
      parity_col_latch_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_en_n <= 1'b1;
      dq_o <= '0;
      dq_oe <= 1'b0;
    end
    else if (state == ST_SETUP)
    begin
      byte_col_latch_n <= (op == CMD_SELF_REFRESH) ? '0 : '1;
      parity_col_latch_n <= (op != CMD_SELF_REFRESH);
      write_strobe_n <= 1'b1;
      dq_o <= mask_word;
      dq_oe <= (op == CMD_WRITE);
    end
    else if (state == ST_ROW && phase_done && op == CMD_WRITE)
      dq_o <= wdata_q;
    else if (state == ST_ROW && phase_done && op == CMD_READ)
      output_en_n <= 1'b0;
    else if (state == ST_COL && op == CMD_WRITE)
    begin
      byte_col_latch_n <= ~ben_q;
      parity_col_latch_n <= ~(|pmask_q);
      write_strobe_n <= 1'b0;
    end
    else if ((state == ST_ACCESS && phase_done) || (state == ST_SELF && !self_refresh_hold))
    begin
      byte_col_latch_n <= '1;
      parity_col_latch_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_en_n <= 1'b1;
    end
    else if (state == ST_RELEASE)
      dq_oe <= 1'b0;
  end
  // ************************************************
  // Read data and last-read-row copy
  // ************************************************
  // Pin data passes two flip-flops before capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
    end
  end
  // Every read cycle leaves its row in the module's latch, hit or miss
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      lrr_row <= '0;
      lrr_valid <= 1'b0;
    end
    else if (state == ST_ACCESS && phase_done && op == CMD_READ)
    begin
      rsp_valid <= init_done; // Start-up reads are not answered
      rsp_rdata <= dq_s2;
      lrr_row <= row_q;
      lrr_valid <= 1'b1;
    end
    else
      rsp_valid <= 1'b0; // Answer lasts one cycle
  end
  // Ten start-up cycles counted as each one releases
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_step <= 4'h0;
      init_done <= 1'b0;
    end
    else if (state == ST_RELEASE && !init_done)
    begin
      init_step <= init_step + 4'h1;
      init_done <= (init_step == 4'(`CDR_INIT_CYCLES - 1));
    end
  end
  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] high_cnt; // Cycles row strobe has been high, saturating
  logic [GW-1:0] since_ref; // Cycles since last internal refresh
  logic was_self; // Last row low was a self refresh
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_cnt <= 8'h00;
      since_ref <= '0;
      was_self <= 1'b0;
    end
    else
    begin
      high_cnt <= !row_strobe_n ? 8'h00 : (high_cnt == 8'hFF ? high_cnt : high_cnt + 8'h01);
      since_ref <= (!refresh_req_n && !row_strobe_n) || state == ST_SELF ? '0 : since_ref + 1'b1;
      if (state == ST_SELF)
        was_self <= 1'b1;
      // Cleared only after the next row fall is sampled, so the exit check can see it
      else if (state == ST_ROW)
        was_self <= 1'b0;
    end
  end
  sequence s_write_fall;
    $fell(row_strobe_n) && write_read_select && refresh_req_n && !select_n;
  endsequence
  a_write_start_strobes: assert property (s_write_fall |-> write_strobe_n && (&byte_col_latch_n))
    else $error("write started with a strobe low");
  a_mask_at_fall: assert property (s_write_fall ##0 state == ST_ROW && op == CMD_WRITE
      |-> dq_oe && dq_o == mask_word)
    else $error("parity mask not on bus at row fall");
  a_strobes_before_pre: assert property ($rose(row_strobe_n) && !was_self
      |-> write_strobe_n && (&byte_col_latch_n) && parity_col_latch_n)
    else $error("row strobe rose with a strobe low");
  a_no_deselect_fall: assert property ($fell(row_strobe_n) && select_n
      |-> !refresh_req_n || !byte_col_latch_n[0])
    else $error("row cycle started on deselected module");
  a_refresh_gap: assert property (since_ref <= GW'(REFRESH_GAP_CYC))
    else $error("internal refresh interval exceeded");
  a_powerup_wait: assert property ($fell(row_strobe_n) && init_step == 4'h0 && !init_done
      |-> high_cnt >= 8'(`CDR_INIT_WAIT_CYC))
    else $error("start-up cycle before power-up wait");
  a_self_exit_pre: assert property ($fell(row_strobe_n) && was_self
      |-> high_cnt >= SR_EXIT_LEN + 8'h01)
    else $error("self refresh exit precharge too short");
  a_static_read: assert property (state == ST_ACCESS && op == CMD_READ
      |-> (&byte_col_latch_n) && parity_col_latch_n && !output_en_n)
    else $error("read left static column mode");
  a_byte_lanes: assert property (state == ST_COL && op == CMD_WRITE
      |=> byte_col_latch_n == ~ben_q && !write_strobe_n)
    else $error("byte lane strobes do not match enables");
endmodule // cdr_host_ctrl
`default_nettype wire

// >>> cdr_host_ctrl_tb.sv
// Self-checking bench for the cached DRAM host controller.
// Assumes the pin model file is compiled before this one.
`timescale 1ns/1ns
`default_nettype none
module cdr_host_ctrl_tb;
  import cdr_pkg::*;
  // ****
  // Stimulus and wiring
  // ****
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic self_refresh_hold = 1'b0;
  cdr_cmd_t req_cmd = CMD_READ;
  logic [10:0] req_row = 11'h000;
  logic [8:0] req_col = 9'h000;
  logic [35:0] req_wdata = 36'h000000000;
  logic [3:0] req_byte_en = 4'h0;
  logic [3:0] req_par_mask = 4'h0;
  logic req_ready, rsp_valid, init_done, cache_hit, row_strobe_n, select_n, write_read_select;
  logic refresh_req_n, parity_col_latch_n, write_strobe_n, output_en_n, dq_oe;
  logic [3:0] byte_col_latch_n;
  logic [10:0] addr;
  logic [35:0] rsp_rdata, dq_o, dq_i, got, e;
  int err_total = 0;
  int checked = 0;
  int n0;
  int n1;
  always #20 clk = ~clk;
  // Short refresh gap keeps the periodic refresh visible in a brief run
  cdr_host_ctrl #(.REFRESH_GAP_CYC(100)) DUT (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .req_byte_en(req_byte_en), .req_par_mask(req_par_mask),
    .self_refresh_hold(self_refresh_hold), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .cache_hit(cache_hit), .row_strobe_n(row_strobe_n),
    .select_n(select_n), .write_read_select(write_read_select), .refresh_req_n(refresh_req_n),
    .byte_col_latch_n(byte_col_latch_n), .parity_col_latch_n(parity_col_latch_n),
    .write_strobe_n(write_strobe_n), .output_en_n(output_en_n), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i));
  cdr_dram_model u_mem (.row_strobe_n(row_strobe_n), .select_n(select_n),
    .write_read_select(write_read_select), .refresh_req_n(refresh_req_n),
    .byte_col_latch_n(byte_col_latch_n), .parity_col_latch_n(parity_col_latch_n),
    .write_strobe_n(write_strobe_n), .output_en_n(output_en_n), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One request, held from a falling edge until the take, then run to idle
  task automatic issue(input cdr_cmd_t c, input logic [10:0] r, input logic [35:0] d,
    input logic [3:0] be, input logic [3:0] pm);
    for (int n = 0; n < 400 && req_ready !== 1'b1; n++)
      @(negedge clk);
    req_cmd = c;
    req_row = r;
    req_col = 9'h003;
    req_wdata = d;
    req_byte_en = be;
    req_par_mask = pm;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (int n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
        got = rsp_rdata;
      if (req_ready === 1'b1)
        break;
    end
  endtask
  task automatic rd(input logic [35:0] exp);
    got = 36'h000000000;
    issue(CMD_READ, 11'h005, 36'h000000000, 4'h0, 4'h0);
    chk(got, exp);
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_init;
    for (int n = 0; n < 1000 && init_done !== 1'b1; n++)
      @(negedge clk);
    chk(36'(init_done), 36'h1);
    chk(36'(u_mem.refreshes >= 8), 36'h1);
    chk(36'(u_mem.reads), 36'h2);
    chk(36'(u_mem.last_read_row_latch), 36'h1);
    $display("test init done");
  endtask
  task automatic t_write_miss;
    issue(CMD_WRITE, 11'h005, 36'h9A5C33C5A, 4'hF, 4'hF);
    chk(36'(u_mem.last_read_row_latch), 36'h1);
    chk(36'(u_mem.bad), 36'h0);
    rd(36'h9A5C33C5A);
    $display("test write miss done");
  endtask
  task automatic t_write_hit;
    e = 36'h9A5C33C5A;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 0 || i == 2)
        e[9*i+:8] = 8'(36'h65A3CC3A5 >> (9 * i));
      if (i == 1)
        e[9*i+8] = 1'b0;
    end
    issue(CMD_WRITE, 11'h005, 36'h65A3CC3A5, 4'h5, 4'h2);
    chk(36'(u_mem.hit), 36'h1);
    chk(u_mem.cache[3], e);
    rd(e);
    $display("test write hit done");
  endtask
  task automatic t_refreshes;
    n0 = u_mem.row_only;
    issue(CMD_ROW_REFRESH, 11'h005, 36'h000000000, 4'h0, 4'h0);
    chk(36'(u_mem.row_only), 36'(n0 + 1));
    chk(36'(u_mem.row), 36'h005);
    n0 = u_mem.refreshes;
    issue(CMD_REFRESH, 11'h000, 36'h000000000, 4'h0, 4'h0);
    chk(36'(u_mem.refreshes > n0), 36'h1);
    rd(e);
    n0 = u_mem.refreshes;
    n1 = u_mem.reads;
    repeat (350) @(negedge clk);
    chk(36'(u_mem.refreshes - n0 >= 3), 36'h1);
    chk(36'(u_mem.reads - n1), 36'h0);
    $display("test refresh done");
  endtask
  task automatic t_self;
    self_refresh_hold = 1'b1;
    fork
      issue(CMD_SELF_REFRESH, 11'h000, 36'h000000000, 4'h0, 4'h0);
      begin
        repeat (25) @(negedge clk);
        chk(36'(u_mem.self_on), 36'h1);
        chk(36'(select_n), 36'h1);
        self_refresh_hold = 1'b0;
      end
    join
    rd(e);
    chk(36'(u_mem.selfs), 36'h1);
    chk(36'(u_mem.bad), 36'h0);
    req_row = 11'h005;
    #1;
    chk(36'(cache_hit), 36'h1);
    @(negedge clk);
    req_row = 11'h001;
    #1;
    chk(36'(cache_hit), 36'h0);
    $display("test self refresh done");
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_init;
    t_write_miss;
    t_write_hit;
    t_refreshes;
    t_self;
    results;
  end
  // Whole run is under a thousand cycles; this limit is ten thousand
  initial
  begin
    #400000;
    err_total++;
    results;
  end
endmodule // cdr_host_ctrl_tb
`default_nettype wire

// >>> cdr_interval_timer.sv
// Interval timer that raises a sticky due flag every PERIOD cycles.
// Assumes clear is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module cdr_interval_timer #(
  parameter int unsigned PERIOD = 1530
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  output logic due
);
  localparam int unsigned W = $clog2(PERIOD + 1);
  logic [W-1:0] count; // Cycles since last clear or expiry
  logic hit; // Period elapsed this cycle
  assign hit = (count == W'(PERIOD - 1));
  // ************************************************
  // Counter and due flag
  // ************************************************
  // Counter restarts on every issued refresh
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count <= '0;
    else if (clear || hit)
      count <= '0;
    else
      count <= count + 1'b1;
  end
  // Expiry wins over a clear in the same cycle, so no period is lost
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      due <= 1'b0;
    else if (hit)
      due <= 1'b1;
    else if (clear)
      due <= 1'b0;
  end
  a_due_on_period: assert property (@(posedge clk) disable iff (!nrst) hit |=> due)
    else $error("due flag not raised at period end");
endmodule // cdr_interval_timer
`default_nettype wire

// >>> cdr_map.svh
// Pin timing and layout constants for the cached DRAM host controller.
// Assumes a 25 MHz system clock; all nanosecond timings convert to cycle counts through it.
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH
`define CDR_ADDR_W 11
`define CDR_COL_W 9
`define CDR_DATA_W 36
`define CDR_LANES 4
`define CDR_LANE_BITS 9
`define CDR_PAR_POS 8
`define CDR_CLK_NS 40
`define CDR_CEIL_CYC(ns) (((ns) + `CDR_CLK_NS - 1) / `CDR_CLK_NS)
`define CDR_INIT_WAIT_NS 300
`define CDR_INIT_WAIT_CYC `CDR_CEIL_CYC(`CDR_INIT_WAIT_NS)
`define CDR_INIT_REFRESHES 8
`define CDR_INIT_CYCLES 10
`define CDR_REFRESH_WINDOW_NS 64000000
`define CDR_REFRESH_COUNT 1024
`define CDR_REFRESH_GAP_CYC (`CDR_REFRESH_WINDOW_NS / `CDR_CLK_NS / `CDR_REFRESH_COUNT)
`define CDR_REFRESH_SLACK_CYC 32
`define CDR_ROW_HOLD_NS 40
`define CDR_ROW_ACTIVE_NS 80
`define CDR_ACCESS_NS 40
`define CDR_WRITE_NS 40
`define CDR_PRECHARGE_NS 80
`define CDR_WRR_NS 120
`define CDR_SR_EXIT_NS 120
`define CDR_SYNC_STAGES 2
`endif

// >>> cdr_pkg.sv
// Types shared by the cached DRAM host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package cdr_pkg;
  // Commands the user side may ask for
  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_REFRESH = 3'b010,
    CMD_ROW_REFRESH = 3'b011,
    CMD_SELF_REFRESH = 3'b100
  } cdr_cmd_t;
  // Sequencer phases
  typedef enum logic [3:0] {
    ST_POWERUP = 4'b0000,
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ROW = 4'b0011,
    ST_COL = 4'b0100,
    ST_ACCESS = 4'b0101,
    ST_SELF = 4'b0110,
    ST_RELEASE = 4'b0111,
    ST_PRE = 4'b1000
  } cdr_state_t;
endpackage
